// ==== rtl/phy_event_pkg.sv ====
// package: register map, field layout and timing for the phy event block
package phy_event_pkg;
  // register offsets (16-bit registers, plain port addressing)
  localparam logic [7:0]  ENABLE_OFFSET    = 8'h10;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h11;
  localparam logic [7:0]  CONFIG_OFFSET    = 8'h12;
  localparam logic [7:0]  HOSTMASK_OFFSET  = 8'h13;
  localparam logic [7:0]  HOSTSTAT_OFFSET  = 8'h14;
  // field positions
  localparam int          COLLISION_BIT    = 5;
  localparam int          RECOVERY_BIT     = 4;
  localparam int          REMOTE_JAB_BIT   = 3;
  localparam int          LOCAL_JAB_BIT    = 2;
  localparam int          PLCA_CHG_BIT     = 1;
  localparam int          LINK_CHG_BIT     = 0;
  localparam int          NUM_EVENTS       = 6;
  localparam int          COORD_BIT        = 0;
  // reset values
  localparam logic [5:0]  ENABLE_RESET     = 6'h00;
  localparam logic [5:0]  STATUS_RESET     = 6'h00;
  localparam logic        HOSTMASK_RESET   = 1'b0;
  // timing: line bit time 100 ns at 10 Mb/s
  localparam int          BIT_TIME_NS      = 100;
  localparam int          CLK_PERIOD_NS    = 8;
  localparam int          BIT_CYCLES       = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int          JABBER_BYTES     = 2000;
  localparam int          JABBER_CYCLES    = JABBER_BYTES * 8 * BIT_CYCLES;
  localparam int          FALSE_CRS_BT     = 256;
  localparam int          FALSE_CRS_CYCLES = FALSE_CRS_BT * BIT_CYCLES;
  localparam int          QUIET_BT         = 64;
  localparam int          QUIET_CYCLES     = QUIET_BT * BIT_CYCLES;
endpackage : phy_event_pkg

// ==== rtl/event_latch.sv ====
// file: one sticky event bit with read-clear and its enable gate
`timescale 1ns/10ps
`default_nettype none
module event_latch (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic event_i,
  input  wire logic clear_i,
  input  wire logic enable_i,
  output var  logic latched_o,
  output var  logic request_o
);
  typedef struct packed {
    logic latched;
  } latch_state_t;

  latch_state_t state_ff;
  latch_state_t nxt_state;

  // set wins over the read clear so no event is lost
  always_comb begin
    nxt_state = state_ff;
    if (clear_i) begin
      nxt_state.latched = 1'b0;
    end
    if (event_i) begin
      nxt_state.latched = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign latched_o = state_ff.latched;
  assign request_o = state_ff.latched & enable_i;

  a_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    event_i |=> latched_o)
    else $error("event lost in latch");
endmodule : event_latch
`default_nettype wire

// ==== rtl/phy_event_interrupt_mask.sv ====
// file: phy event enables, detectors, status latch and request output
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module phy_event_interrupt_mask #(
  parameter int JABBER_LIMIT = phy_event_pkg::JABBER_CYCLES,
  parameter int FALSE_CRS    = phy_event_pkg::FALSE_CRS_CYCLES,
  parameter int QUIET_TIME   = phy_event_pkg::QUIET_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output var  logic [15:0] rdata_o,
  input  wire logic        collision_i,
  input  wire logic        crs_i,
  input  wire logic        rx_packet_i,
  input  wire logic        line_active_i,
  input  wire logic        local_jabber_i,
  input  wire logic        plca_status_i,
  input  wire logic        link_status_i,
  input  wire logic        beacon_rx_i,
  output var  logic        beacon_tx_o,
  output var  logic        to_allowed_o,
  output var  logic        phy_event_request_o,
  output var  logic        irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    REC_IDLE   = 4'h1,
    REC_QUIET  = 4'h2,
    REC_WAIT_B = 4'h4,
    REC_BEACON = 4'h8
  } rec_state_t;

  typedef struct packed {
    logic [5:0]  enable;
    logic        coordinator;
    logic        host_mask;
    logic        host_stat;
    logic [15:0] rdata;
    logic [31:0] jab_cnt;
    logic [31:0] crs_cnt;
    logic [31:0] quiet_cnt;
    logic        crs_prev;
    logic        plca_prev;
    logic        link_prev;
    logic        rec_event;
    logic        jab_event;
    logic        jab_seen;
    rec_state_t  rec;
    logic        beacon_tx;
    logic        to_allowed;
    logic        request;
    logic        irq;
  } top_state_t;

  top_state_t   state_ff;
  top_state_t   nxt_state;
  logic [5:0]   events;
  logic [5:0]   latched;
  logic [5:0]   gated;
  logic         status_rd;
  logic         hoststat_wr1;

  assign status_rd = rd_i && (addr_i == phy_event_pkg::STATUS_OFFSET);
  assign hoststat_wr1 = wr_i && (addr_i == phy_event_pkg::HOSTSTAT_OFFSET)
                        && wdata_i[0];

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  // event sources; collision and local jabber pass through as levels, the other four are one-cycle pulses
  always_comb begin
    events = '0;
    events[phy_event_pkg::COLLISION_BIT]  = collision_i;
    events[phy_event_pkg::RECOVERY_BIT]   = state_ff.rec_event;
    events[phy_event_pkg::REMOTE_JAB_BIT] = state_ff.jab_event;
    events[phy_event_pkg::LOCAL_JAB_BIT]  = local_jabber_i;
    events[phy_event_pkg::PLCA_CHG_BIT]   =
      plca_status_i ^ state_ff.plca_prev;
    events[phy_event_pkg::LINK_CHG_BIT]   =
      link_status_i ^ state_ff.link_prev;
  end

  // one sticky latch per source, all sharing the read-clear strobe
  for (genvar g = 0; g < phy_event_pkg::NUM_EVENTS; g++) begin : g_lat
    event_latch u_latch (
      .mclk_i    (mclk_i),
      .rst_n_i   (rst_n_i),
      .event_i   (events[g]),
      .clear_i   (status_rd),
      .enable_i  (state_ff.enable[g]),
      .latched_o (latched[g]),
      .request_o (gated[g])
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.crs_prev  = crs_i;
    nxt_state.plca_prev = plca_status_i;
    nxt_state.link_prev = link_status_i;
    nxt_state.rec_event = 1'b0;
    nxt_state.jab_event = 1'b0;
    nxt_state.beacon_tx = 1'b0;

    // remote jabber: one event per over-long burst on the line
    if (line_active_i) begin
      if (state_ff.jab_cnt < 32'(JABBER_LIMIT)) begin
        nxt_state.jab_cnt = state_ff.jab_cnt + 32'h1;
      end else if (!state_ff.jab_seen) begin
        nxt_state.jab_event = 1'b1;
        nxt_state.jab_seen  = 1'b1;
      end
    end else begin
      nxt_state.jab_cnt  = '0;
      nxt_state.jab_seen = 1'b0;
    end

    // false carrier: carrier seen but no packet before the timeout
    if (crs_i && !state_ff.crs_prev) begin
      nxt_state.crs_cnt = 32'h1;
    end else if (rx_packet_i) begin
      nxt_state.crs_cnt = '0;
    end else if (state_ff.crs_cnt != '0) begin
      if (state_ff.crs_cnt >= 32'(FALSE_CRS)) begin
        nxt_state.crs_cnt   = '0;
        nxt_state.rec_event = 1'b1;
      end else begin
        nxt_state.crs_cnt = state_ff.crs_cnt + 32'h1;
      end
    end

    // recovery sequencing by role
    case (state_ff.rec)
      REC_IDLE: begin
        nxt_state.to_allowed = 1'b1;
        if (state_ff.rec_event) begin
          nxt_state.to_allowed = 1'b0;
          nxt_state.quiet_cnt  = '0;
          nxt_state.rec = state_ff.coordinator ? REC_QUIET : REC_WAIT_B;
        end
      end
      REC_QUIET: begin
        // any activity restarts the quiet window
        if (line_active_i) begin
          nxt_state.quiet_cnt = '0;
        end else if (state_ff.quiet_cnt >= 32'(QUIET_TIME - 1)) begin
          nxt_state.rec = REC_BEACON;
        end else begin
          nxt_state.quiet_cnt = state_ff.quiet_cnt + 32'h1;
        end
      end
      REC_BEACON: begin
        nxt_state.beacon_tx = 1'b1;
        nxt_state.rec = REC_IDLE;
      end
      REC_WAIT_B: begin
        if (beacon_rx_i) begin
          nxt_state.rec = REC_IDLE;
        end
      end
      default: nxt_state.rec = REC_IDLE;
    endcase

    // register writes; the six enable bits, the coordinator bit and the host mask are stored
    if (wr_i) begin
      case (addr_i)
        phy_event_pkg::ENABLE_OFFSET:
          nxt_state.enable = wdata_i[5:0];
        phy_event_pkg::CONFIG_OFFSET:
          nxt_state.coordinator = wdata_i[phy_event_pkg::COORD_BIT];
        phy_event_pkg::HOSTMASK_OFFSET:
          nxt_state.host_mask = wdata_i[0];
        default: ;
      endcase
    end

    // separate request acknowledged by reading its own status
    nxt_state.request = |(gated & ~(status_rd ? latched & ~events : 6'h00))
                        | |(state_ff.enable & events);

    // host-side sticky bit for the request rising; set beats clear
    if (hoststat_wr1) begin
      nxt_state.host_stat = 1'b0;
    end
    if (nxt_state.request && !state_ff.request) begin
      nxt_state.host_stat = 1'b1;
    end
    nxt_state.irq = nxt_state.host_stat & state_ff.host_mask;

    // read data, one cycle after the strobe; unmapped reads zero
    nxt_state.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        phy_event_pkg::ENABLE_OFFSET:
          nxt_state.rdata = {10'h000, state_ff.enable};
        phy_event_pkg::STATUS_OFFSET:
          nxt_state.rdata = {10'h000, latched};
        phy_event_pkg::CONFIG_OFFSET:
          nxt_state.rdata = {15'h0000, state_ff.coordinator};
        phy_event_pkg::HOSTMASK_OFFSET:
          nxt_state.rdata = {15'h0000, state_ff.host_mask};
        phy_event_pkg::HOSTSTAT_OFFSET:
          nxt_state.rdata = {15'h0000, state_ff.host_stat};
        default: nxt_state.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff            <= '0;
      state_ff.enable     <= phy_event_pkg::ENABLE_RESET;
      state_ff.host_mask  <= phy_event_pkg::HOSTMASK_RESET;
      state_ff.rec        <= REC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_o             = state_ff.rdata;
  assign beacon_tx_o         = state_ff.beacon_tx;
  assign to_allowed_o        = state_ff.to_allowed;
  assign phy_event_request_o = state_ff.request;
  assign irq_o               = state_ff.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_collision_req: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    collision_i && state_ff.enable[phy_event_pkg::COLLISION_BIT]
    |=> phy_event_request_o)
    else $error("collision did not raise request");
  a_recovery_req: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.rec_event && state_ff.enable[phy_event_pkg::RECOVERY_BIT]
    |=> phy_event_request_o)
    else $error("recovery did not raise request");
  a_false_crs: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.rec_event |-> $past(state_ff.crs_cnt) != '0)
    else $error("recovery without pending carrier");
  a_beacon_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    beacon_tx_o |-> state_ff.coordinator && !$past(line_active_i))
    else $error("beacon sent without quiet line");
  a_follower_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.rec == REC_WAIT_B && !beacon_rx_i |=> !to_allowed_o)
    else $error("opportunity taken before beacon");
  a_jabber_req: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.jab_event && state_ff.enable[phy_event_pkg::REMOTE_JAB_BIT]
    |=> phy_event_request_o)
    else $error("remote jabber did not raise request");
  a_jabber_len: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.jab_event |-> state_ff.jab_cnt == 32'(JABBER_LIMIT))
    else $error("remote jabber flagged early");
  a_local_req: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    local_jabber_i && state_ff.enable[phy_event_pkg::LOCAL_JAB_BIT]
    |=> phy_event_request_o)
    else $error("local jabber did not raise request");
  a_plca_req: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(plca_status_i) && state_ff.enable[phy_event_pkg::PLCA_CHG_BIT]
    |=> phy_event_request_o)
    else $error("plca change did not raise request");
  a_link_req: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $changed(link_status_i) && state_ff.enable[phy_event_pkg::LINK_CHG_BIT]
    |=> phy_event_request_o)
    else $error("link change did not raise request");
  a_enable_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rd_i && addr_i == phy_event_pkg::ENABLE_OFFSET |=> rdata_o[15:6] == 10'h000)
    else $error("unused enable bits not zero");
  a_req_masked: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    phy_event_request_o |-> |($past(latched | events) & $past(state_ff.enable)))
    else $error("request without enabled latched source");
  // a quiet status read must leave every sticky bit clear
  a_status_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    status_rd && events == 6'h00 |=> latched == 6'h00)
    else $error("status bits survived a read");
  // the acknowledge read drops the request when nothing new arrived
  a_req_drop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    status_rd && events == 6'h00 |=> !phy_event_request_o)
    else $error("request held after acknowledge");
  // the host flag only reaches its pin through its own mask
  a_irq_masked: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_o |-> $past(state_ff.host_mask))
    else $error("host interrupt while masked");
  // the host flag stays until its own write-one acknowledge
  a_host_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_ff.host_stat && !hoststat_wr1 |=> state_ff.host_stat)
    else $error("host flag lost without acknowledge");
  // read data stand for one cycle only, zero otherwise
  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read cycle");
endmodule : phy_event_interrupt_mask
`default_nettype wire

// ==== tb/phy_event_interrupt_mask_bench.sv ====
// file: self-checking bench for the phy event enable and request block
`timescale 1ns/10ps
`default_nettype none
`define chk(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module phy_event_interrupt_mask_bench;
  // short counts keep the run brief; every expectation uses these values
  localparam int         jab   = 50;
  localparam int         fcrs  = 20;
  localparam int         quiet = 10;
  localparam logic [7:0] en_a  = phy_event_pkg::ENABLE_OFFSET;
  localparam logic [7:0] st_a  = phy_event_pkg::STATUS_OFFSET;
  localparam logic [7:0] cf_a  = phy_event_pkg::CONFIG_OFFSET;
  localparam logic [7:0] hm_a  = phy_event_pkg::HOSTMASK_OFFSET;
  localparam logic [7:0] hs_a  = phy_event_pkg::HOSTSTAT_OFFSET;
  logic        mclk, rst_n, wr, rd, rd_d, look_v, le;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, re;
  logic        collision, crs, rx_packet, line_active, local_jabber;
  logic        plca_status, link_status, beacon_rx, beacon_tx;
  logic        to_allowed, request, irq;
  logic [15:0] rd_q[$];
  string       rd_n[$];
  logic        lk_q[$];
  int          lk_k[$];
  string       lk_n[$];
  string       rn;
  int          miscompares = 0;
  int          compares = 0;
  int          n, lk;
  logic [31:0] r;

  phy_event_interrupt_mask #(.JABBER_LIMIT(jab), .FALSE_CRS(fcrs),
    .QUIET_TIME(quiet)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .collision_i(collision),
    .crs_i(crs), .rx_packet_i(rx_packet), .line_active_i(line_active),
    .local_jabber_i(local_jabber), .plca_status_i(plca_status),
    .link_status_i(link_status), .beacon_rx_i(beacon_rx),
    .beacon_tx_o(beacon_tx), .to_allowed_o(to_allowed),
    .phy_event_request_o(request), .irq_o(irq));

  // ------------------------------------------------------------------
  // clock, monitor and closing
  // ------------------------------------------------------------------
  // 125 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic sig(input int k);
    case (k)
      0: return request;
      1: return irq;
      2: return to_allowed;
      default: return beacon_tx;
    endcase
  endfunction : sig

  // read data stand only in the cycle after the strobe, so mark it
  always @(posedge mclk) rd_d <= rd;

  // mid-cycle compare keeps clear of edge races
  always @(negedge mclk) begin
    if (rd_d === 1'b1) begin
      re = rd_q.pop_front();
      rn = rd_n.pop_front();
      `chk(rn, re, rdata)
    end
    if (look_v === 1'b1) begin
      le = lk_q.pop_front();
      rn = lk_n.pop_front();
      lk = lk_k.pop_front();
      `chk(rn, le, sig(lk))
    end
  end

  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // watchdog sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    stop_test();
  end

  // ------------------------------------------------------------------
  // drivers: entered just after a rising edge
  // ------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e,
                        input string nm);
    rd_q.push_back(e);
    rd_n.push_back(nm);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
  endtask : rd_reg

  task automatic look(input int k, input logic e, input string nm);
    lk_q.push_back(e);
    lk_k.push_back(k);
    lk_n.push_back(nm);
    look_v <= 1'b1;
    @(posedge mclk);
    look_v <= 1'b0;
    @(posedge mclk);
  endtask : look

  // bounded wait for an output level, checked mid-cycle
  task automatic wait_for(input int k, input logic e, output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (sig(k) !== e && c < 300);
    @(posedge mclk);
  endtask : wait_for

  // raise one event; pulses return right after the strobe drops
  task automatic fire(input int s);
    case (s)
      5: collision <= 1'b1;
      4: {crs, line_active} <= 2'b11;
      3: line_active <= 1'b1;
      2: local_jabber <= 1'b1;
      1: plca_status <= ~plca_status;
      default: link_status <= ~link_status;
    endcase
    repeat (s == 4 ? 30 : (s == 3 ? jab + 10 : 1)) @(posedge mclk);
    {collision, crs, line_active, local_jabber} <= 4'h0;
  endtask : fire

  task automatic beacon;
    beacon_rx <= 1'b1;
    @(posedge mclk);
    beacon_rx <= 1'b0;
    wait_for(2, 1'b1, n);
  endtask : beacon

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, look_v, addr, wdata} = '0;
    {collision, crs, rx_packet, line_active, local_jabber} = '0;
    {plca_status, link_status, beacon_rx} = '0;
    r = $urandom(32'h6412);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    look(2, 1'b1, "opportunities after reset");
    rd_reg(en_a, 16'h0000, "enable reset");
    rd_reg(st_a, 16'h0000, "status reset");
    rd_reg(8'h3F, 16'h0000, "unmapped read");
    wr_reg(en_a, 16'hFFFF);
    rd_reg(en_a, 16'h003F, "enable upper zero");
    r = $urandom;
    wr_reg(en_a, r[15:0]);
    rd_reg(en_a, {10'h000, r[5:0]}, "enable random");
    look(0, 1'b0, "no request idle");
    // every source enabled alone, then masked alone
    for (int s = 0; s < 6; s++) begin
      wr_reg(en_a, 16'(1 << s));
      fire(s);
      wait_for(0, 1'b1, n);
      if (s == 5) `chk("answer cycles", 1, n)
      look(0, 1'b1, "request raised");
      if (s == 4) begin
        look(2, 1'b0, "follower holds");
        beacon();
        look(2, 1'b1, "follower resumes");
      end
      rd_reg(st_a, 16'(1 << s), "status latched");
      look(0, 1'b0, "request acked");
      wr_reg(en_a, 16'h003F ^ 16'(1 << s));
      fire(s);
      repeat (40) @(posedge mclk);
      look(0, 1'b0, "masked source");
      rd_reg(st_a, 16'(1 << s), "masked latched");
      if (s == 4) beacon();
    end
    // carrier followed by a packet in time is no recovery
    wr_reg(en_a, 16'h0010);
    {crs, line_active} <= 2'b11;
    repeat (5) @(posedge mclk);
    rx_packet <= 1'b1;
    @(posedge mclk);
    rx_packet <= 1'b0;
    repeat (30) @(posedge mclk);
    {crs, line_active} <= 2'b00;
    repeat (20) @(posedge mclk);
    look(2, 1'b1, "no false carrier");
    rd_reg(st_a, 16'h0000, "packet cancels");
    // coordinator waits for a quiet line, then sends a beacon
    wr_reg(cf_a, 16'h0001);
    fire(4);
    wait_for(3, 1'b1, n);
    `chk("quiet gap", 1'b1, n >= quiet && n <= quiet + 4)
    rd_reg(st_a, 16'h0010, "recovery latched");
    // host side flag has its own mask and acknowledge
    wr_reg(hm_a, 16'h0001);
    wr_reg(en_a, 16'h0001);
    fire(0);
    wait_for(1, 1'b1, n);
    rd_reg(st_a, 16'h0001, "link change");
    look(0, 1'b0, "request acked");
    look(1, 1'b1, "host flag stays");
    rd_reg(hs_a, 16'h0001, "host status");
    wr_reg(hs_a, 16'h0001);
    look(1, 1'b0, "host flag cleared");
    wr_reg(hm_a, 16'h0000);
    fire(0);
    wait_for(0, 1'b1, n);
    look(1, 1'b0, "host flag masked");
    wr_reg(hm_a, 16'h0001);
    look(1, 1'b1, "host flag unmasked");
    wr_reg(hs_a, 16'h0001);
    rd_reg(st_a, 16'h0001, "link again");
    look(1, 1'b0, "all clear");
    stop_test();
  end
endmodule : phy_event_interrupt_mask_bench
`default_nettype wire
